//--- logic/card_cycle_start_sequencer.sv
module card_cycle_start_sequencer #(
  parameter int TICK_CYCLES = card_seq_pkg::TICK_CYC
) (
  input wire logic hclk, // System clock, 40 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write direction
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic hreadyout, // Always ready, no waits
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic host_transfer_strobe, // Host channel transfer strobe
  input wire logic channel_ack_flag, // Channel acknowledge level
  input wire logic unit_ready, // Unit ready level
  input wire logic unit_cycle, // Unit card cycle level
  input wire logic unit_read_error_level, // Unit read check level
  input wire logic unit_punch_error_level, // Unit punch check level
  output logic start_cycle_level, // Start card cycle to unit
  output logic [7:0] parallel_output_lines, // Ops/options or data to unit
  output logic irq // Level interrupt
);

  typedef struct packed {
    card_seq_pkg::seq_state_e state;
    logic [card_seq_pkg::TICK_W-1:0] tick_cnt;
    card_seq_pkg::pins_s s1;
    card_seq_pkg::pins_s s2;
    logic strobe_prev;
    card_seq_pkg::flags_s f;
    card_seq_pkg::ctrl_s ctrl;
    logic [7:0] data;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic ap_valid;
    logic ap_write;
    logic [4:0] ap_addr;
    logic [31:0] rdata;
    logic [7:0] lines;
  } st_s;

  st_s q;
  st_s d;
  logic tick;
  logic qual_strobe;
  logic [3:0] events;
  logic [3:0] w1c;

  // Register word read back at a byte offset
  function automatic logic [31:0] read_word(input st_s s, input logic [4:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      card_seq_pkg::CTRL_OFS: r = {16'h0000, s.ctrl};
      card_seq_pkg::DATA_OFS: r = {24'h00_0000, s.data};
      card_seq_pkg::STATUS_OFS: r = {22'h00_0000, s.state == card_seq_pkg::ST_TEN, s.f};
      card_seq_pkg::IRQ_STAT_OFS: r = {28'h000_0000, s.irq_stat};
      card_seq_pkg::IRQ_MASK_OFS: r = {28'h000_0000, s.irq_mask};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_word

  // Pacing tick from the free-running counter; qualified strobe edge from synchronised levels
  assign tick = (q.tick_cnt == card_seq_pkg::TICK_W'(TICK_CYCLES - 1));
  assign qual_strobe = q.s2.host_transfer_strobe && !q.strobe_prev && q.s2.channel_ack_flag;

  // Next-state logic for the whole block
  always_comb
  begin
    d = q;
    // Two flops on every unit and channel pin before use
    d.s1 = {host_transfer_strobe, channel_ack_flag, unit_ready, unit_cycle,
            unit_read_error_level, unit_punch_error_level};
    d.s2 = q.s1;
    d.strobe_prev = q.s2.host_transfer_strobe;
    d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
    d.f.cycle_in_progress_flag = q.s2.unit_cycle;
    d.f.unit_ready_flag = q.s2.unit_ready;

    // Sequence counter, states nine and ten
    unique case (q.state)
      card_seq_pkg::ST_NINE:
      begin
        if (qual_strobe)
        begin
          // Flags of the last result are dropped when a new op starts
          d.f.operation_started_flag = 1'b0;
          d.f.read_error_flag = 1'b0;
          d.f.punch_error_flag = 1'b0;
          d.f.data_unload_flag = 1'b0;
          d.f.second_pass_flag = !q.ctrl.punch_op_flag && q.ctrl.print_op_flag
                                 && q.ctrl.read_op_flag;
          if (q.f.unit_ready_flag && !q.ctrl.test_op_flag && !q.ctrl.pause_op_flag
              && !q.f.second_pass_flag
              && (!q.ctrl.read_repeat_op || !q.ctrl.read_buffer_full))
          begin
            d.f.card_feed_flag = 1'b1;
          end
          d.state = card_seq_pkg::ST_TEN;
        end
      end
      card_seq_pkg::ST_TEN:
      begin
        if (tick && !q.f.cycle_in_progress_flag && q.f.card_feed_flag)
        begin
          d.f.start_cycle_level = 1'b1;
        end
        if (tick && !q.f.cycle_in_progress_flag && q.f.unit_ready_flag && q.ctrl.read_repeat_op
            && q.ctrl.read_data_loaded && q.ctrl.incomplete_shift_flag)
        begin
          d.f.start_cycle_level = 1'b1;
        end
        if (tick && q.f.second_pass_flag && q.ctrl.incomplete_shift_flag)
        begin
          d.f.data_unload_flag = 1'b1;
        end
        // Leave only once the cycle began, the unit dropped, or nothing is pending
        if (q.f.operation_started_flag || !q.f.unit_ready_flag
            || (!q.f.card_feed_flag && !q.ctrl.read_repeat_op))
        begin
          d.state = card_seq_pkg::ST_NINE;
        end
      end
      default: d.state = card_seq_pkg::ST_NINE;
    endcase

    // Clear has priority over set, a dead unit must never be started
    if ((tick && q.f.cycle_in_progress_flag) || !q.f.unit_ready_flag)
    begin
      d.f.start_cycle_level = 1'b0;
      d.f.card_feed_flag = 1'b0;
    end
    if (q.f.start_cycle_level && q.f.cycle_in_progress_flag)
    begin
      d.f.operation_started_flag = 1'b1;
    end
    if (q.f.cycle_in_progress_flag && q.s2.unit_read_error_level)
    begin
      d.f.read_error_flag = 1'b1;
    end
    // Punch error waits for the cycle to finish; the unit already stacked the card
    if (tick && !q.f.cycle_in_progress_flag && q.s2.unit_punch_error_level)
    begin
      d.f.punch_error_flag = 1'b1;
    end

    // Output lines: data while unloading, else op codes and options
    if (q.f.data_unload_flag)
    begin
      d.lines = q.data;
    end
    else
    begin
      d.lines = {q.ctrl.inhibit_feed, q.ctrl.diff_panel, q.ctrl.second_path, q.ctrl.sec_hopper,
                 q.ctrl.stacker_select_mid, q.ctrl.stacker_select_hi,
                 q.ctrl.print_op_flag, q.ctrl.punch_op_flag};
    end

    // Bus address phase, zero wait states
    d.ap_valid = hsel && htrans[1] && hready;
    d.ap_write = hwrite;
    d.ap_addr = haddr[4:0];
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      d.rdata = read_word(q, haddr[4:0]);
    end
    // Bus data phase write; unmapped offsets are ignored
    if (q.ap_valid && q.ap_write)
    begin
      unique case (q.ap_addr)
        card_seq_pkg::CTRL_OFS: d.ctrl = hwdata[15:0];
        card_seq_pkg::DATA_OFS: d.data = hwdata[7:0];
        card_seq_pkg::IRQ_MASK_OFS: d.irq_mask = hwdata[3:0];
        default: d.rdata = q.rdata;
      endcase
    end

    // Sticky events, set beats a same-cycle write-one clear
    d.irq_stat = (q.irq_stat & ~w1c) | events;
  end

  assign events[card_seq_pkg::EV_OPST] = d.f.operation_started_flag && !q.f.operation_started_flag;
  assign events[card_seq_pkg::EV_RDERR] = d.f.read_error_flag && !q.f.read_error_flag;
  assign events[card_seq_pkg::EV_PUERR] = d.f.punch_error_flag && !q.f.punch_error_flag;
  assign events[card_seq_pkg::EV_NRDY] = !d.f.unit_ready_flag && q.f.unit_ready_flag;
  assign w1c = (q.ap_valid && q.ap_write && q.ap_addr == card_seq_pkg::IRQ_STAT_OFS) ? hwdata[3:0] : 4'h0;

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.state <= card_seq_pkg::ST_NINE;
      q.ctrl <= card_seq_pkg::CTRL_RST;
      q.data <= card_seq_pkg::DATA_RST;
      q.irq_mask <= card_seq_pkg::IRQ_MASK_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign start_cycle_level = q.f.start_cycle_level;
  assign parallel_output_lines = q.lines;
  assign irq = |(q.irq_stat & q.irq_mask);

  // Checks
  loop_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.state == card_seq_pkg::ST_NINE && qual_strobe) |=> (q.f.second_pass_flag ==
    ($past(q.ctrl.print_op_flag) && $past(q.ctrl.read_op_flag) && !$past(q.ctrl.punch_op_flag))))
    else $error("loop flag wrong after strobe");
  unload_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.f.data_unload_flag) |-> $past(q.f.second_pass_flag))
    else $error("unload set without loop flag");
  feed_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.f.card_feed_flag) |-> $past(q.f.unit_ready_flag && !q.ctrl.test_op_flag
    && !q.ctrl.pause_op_flag && !q.f.second_pass_flag && qual_strobe))
    else $error("feed flag set illegally");
  start_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.state == card_seq_pkg::ST_TEN && tick && q.f.card_feed_flag && !q.f.cycle_in_progress_flag
    && q.f.unit_ready_flag) |=> start_cycle_level)
    else $error("start level not raised");
  start_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!q.f.unit_ready_flag || (tick && q.f.cycle_in_progress_flag)) |=> !start_cycle_level
    && !q.f.card_feed_flag)
    else $error("start or feed not cleared");
  start_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(start_cycle_level) |-> $past(tick) && $past(q.state == card_seq_pkg::ST_TEN))
    else $error("start level off tick");
  ready_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !unit_ready ##1 !unit_ready ##1 !unit_ready |=> !q.f.unit_ready_flag)
    else $error("ready flag not reset");
  opst_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (start_cycle_level && q.f.cycle_in_progress_flag) |=> q.f.operation_started_flag)
    else $error("operation start not set");
  rderr_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.f.cycle_in_progress_flag && q.s2.unit_read_error_level) |=> q.f.read_error_flag)
    else $error("read error not captured");
  puerr_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.f.punch_error_flag) |-> $past(tick && !q.f.cycle_in_progress_flag))
    else $error("punch error set off tick or in cycle");
  lines_mux_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.f.data_unload_flag |=> parallel_output_lines == $past(q.data))
    else $error("data not on output lines");
  cip_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
    unit_cycle ##1 unit_cycle ##1 unit_cycle |=> q.f.cycle_in_progress_flag)
    else $error("cycle flag not captured");
  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(q.irq_stat & q.irq_mask))
    else $error("interrupt level wrong");

  card_cycle_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.f.operation_started_flag));
  read_repeat_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(start_cycle_level) && q.ctrl.read_repeat_op);
  unload_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(q.f.data_unload_flag));
  punch_err_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(q.f.punch_error_flag));

endmodule : card_cycle_start_sequencer

//--- logic/card_seq_pkg.sv
package card_seq_pkg;
  // Byte offsets of the register words
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] DATA_OFS = 5'h04;
  localparam logic [4:0] STATUS_OFS = 5'h08;
  localparam logic [4:0] IRQ_STAT_OFS = 5'h0C;
  localparam logic [4:0] IRQ_MASK_OFS = 5'h10;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // Pacing clock: 4 us at a 25 ns system clock
  localparam int TICK_NS = 4000;
  localparam int CLK_NS = 25;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TICK_W = 8;
  // Interrupt event bit positions
  localparam int EV_OPST = 0;
  localparam int EV_RDERR = 1;
  localparam int EV_PUERR = 2;
  localparam int EV_NRDY = 3;

  typedef enum logic [1:0] {ST_NINE, ST_TEN} seq_state_e;

  // Operation and option word written by software
  typedef struct packed {
    logic spare;
    logic inhibit_feed;
    logic diff_panel;
    logic second_path;
    logic sec_hopper;
    logic stacker_select_mid;
    logic stacker_select_hi;
    logic incomplete_shift_flag;
    logic read_data_loaded;
    logic read_buffer_full;
    logic read_repeat_op;
    logic pause_op_flag;
    logic test_op_flag;
    logic read_op_flag;
    logic print_op_flag;
    logic punch_op_flag;
  } ctrl_s;

  // Levels from the card unit and the host channel
  typedef struct packed {
    logic host_transfer_strobe;
    logic channel_ack_flag;
    logic unit_ready;
    logic unit_cycle;
    logic unit_read_error_level;
    logic unit_punch_error_level;
  } pins_s;

  // Sequencer flags, also the low bits of the status word
  typedef struct packed {
    logic punch_error_flag;
    logic read_error_flag;
    logic operation_started_flag;
    logic unit_ready_flag;
    logic cycle_in_progress_flag;
    logic start_cycle_level;
    logic card_feed_flag;
    logic data_unload_flag;
    logic second_pass_flag;
  } flags_s;
endpackage : card_seq_pkg

//--- test/card_cycle_start_sequencer_bench.sv
module card_cycle_start_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, strobe, ack, ready_en, slow, rd_err_en, pu_err_en;
  logic hreadyout, hresp, start, irq, u_rdy, u_cyc, u_rde, u_pue;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] lines;
  logic [15:0] blocked [3] = '{16'h000C, 16'h0014, 16'h0064};
  int error_cnt, n_checks, cyc;

  card_cycle_start_sequencer #(.TICK_CYCLES(8)) i_card_cycle_start_sequencer (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .host_transfer_strobe(strobe),
    .channel_ack_flag(ack), .unit_ready(u_rdy), .unit_cycle(u_cyc), .unit_read_error_level(u_rde),
    .unit_punch_error_level(u_pue), .start_cycle_level(start), .parallel_output_lines(lines), .irq(irq));
  card_unit_model i_card_unit_model (.hclk(hclk), .hresetn(hresetn), .start_cycle_level(start),
    .ready_en(ready_en), .slow(slow), .rd_err_en(rd_err_en), .pu_err_en(pu_err_en), .unit_ready(u_rdy),
    .unit_cycle(u_cyc), .unit_read_error_level(u_rde), .unit_punch_error_level(u_pue));

  // One single-word transfer; waits on hready at both phases
  task automatic bus(input logic wr, input logic [4:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {27'h0, ofs};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    // Let a write that lands on this edge settle before callers look at outputs
    #1;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One status bit
  task automatic st(input int b, input logic v);
    bus(1'b0, card_seq_pkg::STATUS_OFS, 32'h0);
    chk({31'h0, rd[b]}, {31'h0, v});
  endtask : st

  // Bounded wait on start level (0) or unit cycle level (1)
  task automatic wait_lvl(input int which, input logic v);
    int n;
    n = 0;
    while (((which == 0) ? start : u_cyc) !== v && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_lvl

  task automatic pulse_strobe;
    @(posedge hclk);
    strobe <= 1'b1;
    repeat (4) @(posedge hclk);
    strobe <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : pulse_strobe

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Hang guard, far above the several hundred cycles the tests need
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("BAD %0t run did not finish", $time);
      summarize();
    end
  end

  initial
  begin
    {hresetn, hsel, hwrite, strobe, slow, rd_err_en, pu_err_en} = 7'h00;
    {ack, ready_en} = 2'h3;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place, mask read back
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, 5'(i * 4), 32'h0);
      chk(rd, (i == 2) ? 32'h20 : 32'h0);
    end
    bus(1'b1, card_seq_pkg::IRQ_MASK_OFS, 32'hF);
    bus(1'b0, card_seq_pkg::IRQ_MASK_OFS, 32'h0);
    chk(rd, 32'hF);
    chk({31'h0, irq}, 32'h0);
    $display("test registers done");
    // Options on the lines while not unloading
    bus(1'b1, card_seq_pkg::DATA_OFS, 32'h5A);
    bus(1'b1, card_seq_pkg::CTRL_OFS, 32'h5201);
    repeat (2) @(posedge hclk);
    chk({24'h0, lines}, 32'hA5);
    $display("test option lines done");
    // Read op with a read check
    rd_err_en <= 1'b1;
    bus(1'b1, card_seq_pkg::CTRL_OFS, 32'h4);
    pulse_strobe();
    wait_lvl(0, 1'b1);
    chk({31'h0, start}, 32'h1);
    wait_lvl(1, 1'b1);
    repeat (6) @(posedge hclk);
    st(6, 1'b1);
    wait_lvl(1, 1'b0);
    chk({31'h0, start}, 32'h0);
    st(2, 1'b0);
    st(7, 1'b1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, card_seq_pkg::IRQ_STAT_OFS, 32'hF);
    chk({31'h0, irq}, 32'h0);
    rd_err_en <= 1'b0;
    $display("test read op done");
    // Punch check while idle
    pu_err_en <= 1'b1;
    repeat (30) @(posedge hclk);
    st(8, 1'b1);
    pu_err_en <= 1'b0;
    $display("test punch check done");
    // Test, pause and read-repeat with a full buffer feed nothing
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, card_seq_pkg::CTRL_OFS, {16'h0, blocked[i]});
      pulse_strobe();
      repeat (40) @(posedge hclk);
      chk({31'h0, start}, 32'h0);
      st(2, 1'b0);
    end
    bus(1'b1, card_seq_pkg::CTRL_OFS, 32'h1E4);
    wait_lvl(0, 1'b1);
    chk({31'h0, start}, 32'h1);
    wait_lvl(1, 1'b1);
    wait_lvl(1, 1'b0);
    $display("test blocked ops done");
    // Print with read: second pass and unload
    bus(1'b1, card_seq_pkg::CTRL_OFS, 32'h106);
    pulse_strobe();
    wait_lvl(0, 1'b1);
    st(0, 1'b1);
    st(1, 1'b1);
    chk({24'h0, lines}, 32'h5A);
    wait_lvl(1, 1'b1);
    wait_lvl(1, 1'b0);
    pulse_strobe();
    repeat (40) @(posedge hclk);
    chk({31'h0, start}, 32'h0);
    $display("test print read done");
    // Unit drops ready while a start is pending
    slow <= 1'b1;
    bus(1'b1, card_seq_pkg::CTRL_OFS, 32'h4);
    bus(1'b1, card_seq_pkg::IRQ_STAT_OFS, 32'hF);
    pulse_strobe();
    wait_lvl(0, 1'b1);
    ready_en <= 1'b0;
    repeat (6) @(posedge hclk);
    chk({31'h0, start}, 32'h0);
    st(5, 1'b0);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, card_seq_pkg::IRQ_MASK_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, card_seq_pkg::IRQ_STAT_OFS, 32'h8);
    bus(1'b0, card_seq_pkg::IRQ_STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h0);
    {ready_en, slow} <= 2'h2;
    $display("test not ready done");
    summarize();
  end
endmodule : card_cycle_start_sequencer_bench

//--- test/card_unit_model.sv
// Behavioural card unit on the far side of the sequencer
module card_unit_model (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic start_cycle_level, // Start request from sequencer
  input wire logic ready_en, // Bench: unit is ready
  input wire logic slow, // Bench: ignore start requests
  input wire logic rd_err_en, // Bench: read check late in cycle
  input wire logic pu_err_en, // Bench: punch check level
  output logic unit_ready, // Ready level
  output logic unit_cycle, // Card cycle level
  output logic unit_read_error_level, // Read check level
  output logic unit_punch_error_level // Punch check level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] cnt_q;
  // Four cycles of latency, then a 23-cycle card cycle, long enough to span a tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 6'h00;
      unit_cycle <= 1'b0;
    end
    else if (cnt_q != 6'h00)
    begin
      cnt_q <= cnt_q - 6'h01;
      if (cnt_q == 6'h18)
        unit_cycle <= 1'b1;
      else if (cnt_q == 6'h01)
        unit_cycle <= 1'b0;
    end
    else if (start_cycle_level && ready_en && !slow)
      cnt_q <= 6'h1B;
  end
  // Read check only while a card is moving; the failing card is stacked here, unseen
  assign unit_read_error_level = rd_err_en & unit_cycle & (cnt_q < 6'h0C);
  assign unit_punch_error_level = pu_err_en;
  assign unit_ready = ready_en;
endmodule : card_unit_model
